// [rtl/pco_regs.sv]
// Pattern player control, double-buffered settings and per-channel offsets.
// Assumes the serial host front end delivers decoded register requests on
// the DAC clock, and that the trigger pin is asynchronous to that clock.
`timescale 1ns/10ps

module pco_regs #(
  parameter int SAMPLE_WIDTH = 12
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port from the serial host
  input wire pco_pkg::pco_reg_req_type reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Trigger pin, active low
  input wire logic trigger_n_in,
  // Pattern engine handshake
  input wire logic period_done_in,
  output logic pattern_playing_out,
  output logic pattern_start_out,
  output logic sram_access_en_out,
  output logic [15:0] repeat_count_ch4_ch3_out,
  output logic [15:0] repeat_count_ch2_ch1_out,
  // Sample path
  input wire pco_pkg::pco_quad_type sample_in,
  output pco_pkg::pco_quad_type dac_data_out
);

  // ==========================================================
  // Elaboration checks
  if (SAMPLE_WIDTH != 12) begin : g_width_check
    $error("pco_regs supports only 12-bit samples");
  end

  // ==========================================================
  // Address decode helper, used for reads and writes
  function automatic logic [3:0] slot_of(input logic [15:0] addr);
    logic [3:0] s;
    unique case (addr)
      pco_pkg::PCO_ADDR_TYPE: s = {1'b0, pco_pkg::PCO_SLOT_TYPE};
      pco_pkg::PCO_ADDR_DELAY: s = {1'b0, pco_pkg::PCO_SLOT_DELAY};
      pco_pkg::PCO_ADDR_OFS4: s = {1'b0, pco_pkg::PCO_SLOT_OFS4};
      pco_pkg::PCO_ADDR_OFS3: s = {1'b0, pco_pkg::PCO_SLOT_OFS3};
      pco_pkg::PCO_ADDR_OFS2: s = {1'b0, pco_pkg::PCO_SLOT_OFS2};
      pco_pkg::PCO_ADDR_OFS1: s = {1'b0, pco_pkg::PCO_SLOT_OFS1};
      pco_pkg::PCO_ADDR_RPT43: s = {1'b0, pco_pkg::PCO_SLOT_RPT43};
      pco_pkg::PCO_ADDR_RPT21: s = {1'b0, pco_pkg::PCO_SLOT_RPT21};
      default: s = 4'h8;
    endcase
    return s;
  endfunction

  // Saturating signed add, no wrap at the rails
  function automatic logic [11:0] sat_add(input logic [11:0] a,
                                          input logic [11:0] b);
    logic [12:0] sum;
    sum = {a[11], a} + {b[11], b};
    if (sum[12] != sum[11]) begin
      return sum[12] ? pco_pkg::PCO_SAT_MIN : pco_pkg::PCO_SAT_MAX;
    end
    return sum[11:0];
  endfunction

  // ==========================================================
  // Register storage
  logic [15:0] shadow_reg [pco_pkg::PCO_NSLOT];
  logic [15:0] active_reg [pco_pkg::PCO_NSLOT];
  logic [15:0] status_reg;
  logic [15:1] update_rsvd_reg;
  logic commit_reg;
  logic [3:0] wr_slot;
  logic [15:0] rdata_next;

  assign wr_slot = slot_of(reg_req_in.addr);

  // Pending copies; reserved bits are kept as written
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < pco_pkg::PCO_NSLOT; i++) begin
        shadow_reg[i] <= pco_pkg::PCO_RESET_ZERO;
      end
      shadow_reg[pco_pkg::PCO_SLOT_DELAY] <= pco_pkg::PCO_RESET_DELAY;
    end else if (reg_req_in.wr && !wr_slot[3]) begin
      shadow_reg[wr_slot[2:0]] <= reg_req_in.wdata;
    end
  end

  // Update strobe, self-clearing one cycle later
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      commit_reg <= 1'b0;
      update_rsvd_reg <= 15'h0000;
    end else if (reg_req_in.wr && reg_req_in.addr == pco_pkg::PCO_ADDR_UPDATE)
    begin
      commit_reg <= reg_req_in.wdata[pco_pkg::PCO_BIT_COMMIT];
      update_rsvd_reg <= reg_req_in.wdata[15:1];
    end else begin
      commit_reg <= 1'b0;
    end
  end

  // Active copies move only on the update strobe
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < pco_pkg::PCO_NSLOT; i++) begin
        active_reg[i] <= pco_pkg::PCO_RESET_ZERO;
      end
      active_reg[pco_pkg::PCO_SLOT_DELAY] <= pco_pkg::PCO_RESET_DELAY;
    end else if (commit_reg) begin
      for (int i = 0; i < pco_pkg::PCO_NSLOT; i++) begin
        active_reg[i] <= shadow_reg[i];
      end
    end
  end

  // Command bits act at once; playing bit is never stored
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      status_reg <= pco_pkg::PCO_RESET_ZERO;
    end else if (reg_req_in.wr && reg_req_in.addr == pco_pkg::PCO_ADDR_STATUS)
    begin
      status_reg <= reg_req_in.wdata;
      status_reg[pco_pkg::PCO_BIT_PLAYING] <= 1'b0;
    end
  end

  // ==========================================================
  // Read path, one cycle latency
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_req_in.addr == pco_pkg::PCO_ADDR_STATUS) begin
      rdata_next = status_reg;
      rdata_next[pco_pkg::PCO_BIT_PLAYING] = pattern_playing_out;
    end else if (reg_req_in.addr == pco_pkg::PCO_ADDR_UPDATE) begin
      rdata_next = {update_rsvd_reg, commit_reg};
    end else if (!wr_slot[3]) begin
      rdata_next = status_reg[pco_pkg::PCO_BIT_BUF_READ] ?
        active_reg[wr_slot[2:0]] : shadow_reg[wr_slot[2:0]];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        reg_rdata_out <= rdata_next;
      end
    end
  end

  // Copies handed to the SRAM port gate and the pattern engine
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sram_access_en_out <= 1'b0;
      repeat_count_ch4_ch3_out <= 16'h0000;
      repeat_count_ch2_ch1_out <= 16'h0000;
    end else begin
      sram_access_en_out <= status_reg[pco_pkg::PCO_BIT_MEM_ACCESS];
      repeat_count_ch4_ch3_out <= active_reg[pco_pkg::PCO_SLOT_RPT43];
      repeat_count_ch2_ch1_out <= active_reg[pco_pkg::PCO_SLOT_RPT21];
    end
  end

  // ==========================================================
  // Trigger synchroniser and falling edge
  logic trig_meta_reg;
  logic trig_sync_reg;
  logic trig_prev_reg;
  logic trig_fall;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      trig_meta_reg <= 1'b1;
      trig_sync_reg <= 1'b1;
      trig_prev_reg <= 1'b1;
    end else begin
      trig_meta_reg <= trigger_n_in;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  assign trig_fall = trig_prev_reg && !trig_sync_reg;

  // ==========================================================
  // Pattern sequencer
  pco_pkg::pco_state_type state_reg;
  pco_pkg::pco_state_type state_next;
  logic [15:0] delay_cnt_reg;
  logic [7:0] period_cnt_reg;
  logic [7:0] repeat_limit;
  logic run_bit;
  logic finite_mode;
  logic last_period;

  assign run_bit = status_reg[pco_pkg::PCO_BIT_RUN];
  assign finite_mode =
    active_reg[pco_pkg::PCO_SLOT_TYPE][pco_pkg::PCO_BIT_FINITE_REPEAT];
  // Channel 1 count paces the whole pattern; zero still plays once
  assign repeat_limit = active_reg[pco_pkg::PCO_SLOT_RPT21][7:0];
  assign last_period = period_cnt_reg + 8'h01 >= repeat_limit;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pco_pkg::PCO_IDLE: begin
        if (run_bit) state_next = pco_pkg::PCO_ARMED;
      end
      pco_pkg::PCO_ARMED: begin
        if (!run_bit) begin
          state_next = pco_pkg::PCO_IDLE;
        end else if (trig_fall) begin
          state_next = pco_pkg::PCO_DELAY;
        end
      end
      pco_pkg::PCO_DELAY: begin
        if (delay_cnt_reg == 16'h0000) begin
          state_next = pco_pkg::PCO_PLAY;
        end
      end
      pco_pkg::PCO_PLAY: begin
        if (!run_bit && trig_fall) begin
          state_next = pco_pkg::PCO_IDLE;
        end else if (finite_mode && period_done_in && last_period) begin
          state_next = pco_pkg::PCO_IDLE;
        end
      end
    endcase
  end

  // State, playing flag and start pulse move together
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= pco_pkg::PCO_IDLE;
      pattern_playing_out <= 1'b0;
      pattern_start_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      pattern_playing_out <= state_next == pco_pkg::PCO_PLAY;
      pattern_start_out <= state_next == pco_pkg::PCO_PLAY &&
                           state_reg != pco_pkg::PCO_PLAY;
    end
  end

  // Delay counter: load value, play after value plus one cycles
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      delay_cnt_reg <= pco_pkg::PCO_RESET_DELAY;
    end else if (state_reg == pco_pkg::PCO_ARMED) begin
      delay_cnt_reg <= active_reg[pco_pkg::PCO_SLOT_DELAY];
    end else if (state_reg == pco_pkg::PCO_DELAY) begin
      delay_cnt_reg <= delay_cnt_reg - 16'h0001;
    end
  end

  // Period counter, meaningful only in finite mode
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || state_reg != pco_pkg::PCO_PLAY) begin
      period_cnt_reg <= 8'h00;
    end else if (period_done_in && !last_period) begin
      period_cnt_reg <= period_cnt_reg + 8'h01;
    end
  end

  // ==========================================================
  // Offset stage; one process owns the whole output word, channel 1 is
  // word 0 and takes the highest offset slot
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      dac_data_out <= '0;
    end else begin
      for (int ch = 0; ch < 4; ch++) begin
        dac_data_out.word[ch] <= sat_add(sample_in.word[ch],
          active_reg[pco_pkg::PCO_SLOT_OFS1 - 3'(ch)]
            [pco_pkg::PCO_OFS_MSB:pco_pkg::PCO_OFS_LSB]);
      end
    end
  end

endmodule

// [rtl/pco_pkg.sv]
// Package for the pattern control and digital offset register block.
// Assumes one DAC clock domain and a register port behind the serial host.
package pco_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [15:0] PCO_ADDR_UPDATE = 16'h001D;
  localparam logic [15:0] PCO_ADDR_STATUS = 16'h001E;
  localparam logic [15:0] PCO_ADDR_TYPE = 16'h001F;
  localparam logic [15:0] PCO_ADDR_DELAY = 16'h0020;
  localparam logic [15:0] PCO_ADDR_OFS4 = 16'h0022;
  localparam logic [15:0] PCO_ADDR_OFS3 = 16'h0023;
  localparam logic [15:0] PCO_ADDR_OFS2 = 16'h0024;
  localparam logic [15:0] PCO_ADDR_OFS1 = 16'h0025;
  localparam logic [15:0] PCO_ADDR_RPT43 = 16'h002A;
  localparam logic [15:0] PCO_ADDR_RPT21 = 16'h002B;

  // ==========================================================
  // Slots of the double-buffered registers
  localparam int PCO_NSLOT = 8;
  localparam logic [2:0] PCO_SLOT_TYPE = 3'h0;
  localparam logic [2:0] PCO_SLOT_DELAY = 3'h1;
  localparam logic [2:0] PCO_SLOT_OFS4 = 3'h2;
  localparam logic [2:0] PCO_SLOT_OFS3 = 3'h3;
  localparam logic [2:0] PCO_SLOT_OFS2 = 3'h4;
  localparam logic [2:0] PCO_SLOT_OFS1 = 3'h5;
  localparam logic [2:0] PCO_SLOT_RPT43 = 3'h6;
  localparam logic [2:0] PCO_SLOT_RPT21 = 3'h7;

  // ==========================================================
  // Field positions
  localparam int PCO_BIT_COMMIT = 0;
  localparam int PCO_BIT_RUN = 0;
  localparam int PCO_BIT_PLAYING = 1;
  localparam int PCO_BIT_MEM_ACCESS = 2;
  localparam int PCO_BIT_BUF_READ = 3;
  localparam int PCO_BIT_FINITE_REPEAT = 0;
  localparam int PCO_OFS_MSB = 15;
  localparam int PCO_OFS_LSB = 4;

  // ==========================================================
  // Reset values and saturation limits
  localparam logic [15:0] PCO_RESET_ZERO = 16'h0000;
  localparam logic [15:0] PCO_RESET_DELAY = 16'h000E;
  localparam logic [11:0] PCO_SAT_MAX = 12'h7FF;
  localparam logic [11:0] PCO_SAT_MIN = 12'h800;

  // ==========================================================
  // Types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pco_reg_req_type;

  typedef struct packed {
    logic [3:0][11:0] word; // Index 0 is channel 1
  } pco_quad_type;

  typedef enum logic [1:0] {
    PCO_IDLE = 2'b00,
    PCO_ARMED = 2'b01,
    PCO_DELAY = 2'b10,
    PCO_PLAY = 2'b11
  } pco_state_type;

endpackage

// [bench/pco_regs_monitor.sv]
// Checker for the pattern control and offset register block.
// Assumes one DAC clock domain; it is bound into every pco_regs instance.
`timescale 1ns/10ps
module pco_regs_monitor (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire pco_pkg::pco_reg_req_type reg_req_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // Pattern engine side
  input wire logic pattern_playing_out,
  input wire logic pattern_start_out,
  input wire logic sram_access_en_out,
  input wire logic [15:0] repeat_count_ch2_ch1_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // Helpers and sequences
  logic commit_hit;
  assign commit_hit = reg_req_in.wr && reg_req_in.wdata[0] &&
    reg_req_in.addr == pco_pkg::PCO_ADDR_UPDATE;
  sequence s_read;
    reg_req_in.rd ##1 reg_rvalid_out;
  endsequence
  sequence s_start;
    pattern_start_out ##1 !pattern_start_out;
  endsequence
  // ==========================================
  // Properties
  a_read_answer: assert property (reg_req_in.rd |-> s_read)
    else $error("read not answered next cycle");
  a_no_spur_rvalid: assert property (
    !reg_req_in.rd |=> !reg_rvalid_out)
    else $error("read valid without a read");
  a_unmapped_zero: assert property ((reg_req_in.rd &&
    reg_req_in.addr > pco_pkg::PCO_ADDR_RPT21) |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_start_pulse: assert property (pattern_start_out |-> s_start)
    else $error("start longer than one cycle");
  a_start_with_play: assert property ($rose(pattern_playing_out)
    |-> pattern_start_out) else $error("playing rose without start");
  // Even the shortest delay keeps the flag low for fifteen cycles
  a_start_delay: assert property (pattern_start_out |->
    $past(pattern_playing_out, 14) == 1'b0)
    else $error("pattern started too soon");
  a_sram_follow: assert property ((reg_req_in.wr &&
    reg_req_in.addr == pco_pkg::PCO_ADDR_STATUS) |-> ##2
    sram_access_en_out == $past(reg_req_in.wdata[2], 2))
    else $error("memory access enable wrong");
  // Update write, strobe, active copy, registered output: three edges
  a_count_commit: assert property (
    $changed(repeat_count_ch2_ch1_out) |-> $past(commit_hit, 3))
    else $error("count moved without update");
endmodule

bind pco_regs pco_regs_monitor mon_u (.ref_clk_in, .rst_n_in, .reg_req_in,
  .reg_rdata_out, .reg_rvalid_out, .pattern_playing_out, .pattern_start_out,
  .sram_access_en_out, .repeat_count_ch2_ch1_out);

// [bench/pco_host_model.sv]
// Serial host model issuing register requests to the pattern block.
// Assumes requests are launched just after a rising clock edge.
`timescale 1ns/10ps
module pco_host_model (
  // Clock
  input wire logic ref_clk_in,
  // Register port
  output pco_pkg::pco_reg_req_type reg_req_out,
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  initial reg_req_out = '0;
  // ==========================================
  // Bus cycles; idle lines inverted so stale values cannot pass
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    int i;
    @(posedge ref_clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
    for (i = 0; i < 4 && reg_rvalid_in !== 1'b1; i++) @(posedge ref_clk_in);
    // A missing answer yields an unknown word that no check accepts
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 16'hXXXX;
  endtask
  // Settings only act after this strobe
  task automatic commit();
    wr(pco_pkg::PCO_ADDR_UPDATE, 16'h0001);
  endtask
  // Host never programs a delay below the minimum
  task automatic set_delay(input logic [15:0] d);
    wr(pco_pkg::PCO_ADDR_DELAY, (d < 16'h000E) ? 16'h000E : d);
  endtask
endmodule

// [bench/pco_regs_tb.sv]
// Self-checking bench for the pattern control and offset register block.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/10ps
module pco_regs_tb;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic trigger_n_in = 1'b1;
  logic period_done_in = 1'b0;
  pco_pkg::pco_quad_type sample_in = '0;
  pco_pkg::pco_quad_type dac_data_out;
  pco_pkg::pco_reg_req_type reg_req_in;
  logic [15:0] reg_rdata_out, rd_v, repeat_count_ch4_ch3_out;
  logic [15:0] repeat_count_ch2_ch1_out, w [4];
  logic reg_rvalid_out, pattern_playing_out, pattern_start_out;
  logic sram_access_en_out;
  logic [31:0] lfsr = 32'h267E;
  int n_mismatch = 0, checked = 0, cyc = 0, lat, lat14, i, k;
  always #2 ref_clk_in = ~ref_clk_in;
  pco_regs dut_u (.ref_clk_in, .rst_n_in, .reg_req_in, .reg_rdata_out,
    .reg_rvalid_out, .trigger_n_in, .period_done_in, .pattern_playing_out,
    .pattern_start_out, .sram_access_en_out, .repeat_count_ch4_ch3_out,
    .repeat_count_ch2_ch1_out, .sample_in, .dac_data_out);
  pco_host_model host_u (.ref_clk_in, .reg_req_out(reg_req_in),
    .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));
  // ==========================================
  // Expectation helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Clip rather than wrap, so a large offset cannot flip the sign
  function automatic logic [11:0] sat(input logic [11:0] a, b);
    logic [12:0] s;
    s = {a[11], a} + {b[11], b};
    if (s[12] != s[11]) return s[12] ? 12'h800 : 12'h7FF;
    return s[11:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    host_u.rd(a, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic wrap_up();
    $display("Mismatches %0d in %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // Stimulus tasks; first sample pair pushes both clip limits
  task automatic dcheck(input logic on);
    pco_pkg::pco_quad_type s;
    logic [11:0] o;
    for (k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      s = {lfsr, lfsr[15:0] ^ lfsr[31:16]};
      if (k == 0) s.word[3:2] = {12'h7FF, 12'h800};
      @(posedge ref_clk_in) sample_in <= s;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      for (i = 0; i < 4; i++) begin
        o = on ? w[i][15:4] : 12'h000;
        chk(16'(dac_data_out.word[3-i]), 16'(sat(s.word[3-i], o)));
      end
    end
  endtask
  task automatic fire(output int n);
    @(posedge ref_clk_in) trigger_n_in <= 1'b0;
    for (n = 1; n < 90 && pattern_start_out !== 1'b1; n++)
      @(negedge ref_clk_in);
    @(posedge ref_clk_in) trigger_n_in <= 1'b1;
  endtask
  task automatic pin_low();
    @(posedge ref_clk_in) trigger_n_in <= 1'b0;
    repeat (5) @(posedge ref_clk_in);
    trigger_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  task automatic pd(input int n);
    repeat (n) begin
      @(posedge ref_clk_in) period_done_in <= 1'b1;
      @(posedge ref_clk_in) period_done_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
    end
    @(negedge ref_clk_in);
  endtask
  // Hang guard
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rchk(pco_pkg::PCO_ADDR_STATUS, 16'h0000);
    rchk(pco_pkg::PCO_ADDR_TYPE, 16'h0000);
    rchk(pco_pkg::PCO_ADDR_DELAY, 16'h000E);
    for (i = 0; i < 4; i++)
      rchk(pco_pkg::PCO_ADDR_OFS4 + 16'(i), 16'h0000);
    host_u.wr(16'h0030, 16'hBEEF);
    rchk(16'h0030, 16'h0000);
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      w[i] = (i < 2) ? {i ? 12'h800 : 12'h7FF, lfsr[3:0]} : lfsr[15:0];
      host_u.wr(pco_pkg::PCO_ADDR_OFS4 + 16'(i), w[i]);
      rchk(pco_pkg::PCO_ADDR_OFS4 + 16'(i), w[i]);
    end
    dcheck(1'b0);
    host_u.commit();
    dcheck(1'b1);
    host_u.wr(pco_pkg::PCO_ADDR_OFS4, 16'h1230);
    rchk(pco_pkg::PCO_ADDR_OFS4, 16'h1230);
    host_u.wr(pco_pkg::PCO_ADDR_STATUS, 16'hA5CA);
    rchk(pco_pkg::PCO_ADDR_STATUS, 16'hA5C8);
    rchk(pco_pkg::PCO_ADDR_OFS4, w[0]);
    host_u.wr(pco_pkg::PCO_ADDR_STATUS, 16'h0004);
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(16'(sram_access_en_out), 16'h0001);
    host_u.wr(pco_pkg::PCO_ADDR_RPT21, 16'h0003);
    host_u.wr(pco_pkg::PCO_ADDR_RPT43, 16'hC35A);
    host_u.set_delay(16'd14);
    host_u.commit();
    // Active copy moves one edge after the strobe, the output one later
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(repeat_count_ch2_ch1_out, 16'h0003);
    chk(repeat_count_ch4_ch3_out, 16'hC35A);
    host_u.wr(pco_pkg::PCO_ADDR_STATUS, 16'h0001);
    fire(lat14);
    rchk(pco_pkg::PCO_ADDR_STATUS, 16'h0003);
    pd(4);
    chk(16'(pattern_playing_out), 16'h0001);
    host_u.wr(pco_pkg::PCO_ADDR_STATUS, 16'h0000);
    pin_low();
    chk(16'(pattern_playing_out), 16'h0000);
    host_u.set_delay(16'd20);
    host_u.wr(pco_pkg::PCO_ADDR_TYPE, 16'h0001);
    host_u.commit();
    host_u.wr(pco_pkg::PCO_ADDR_STATUS, 16'h0001);
    fire(lat);
    chk(16'(lat - lat14), 16'd6);
    pd(2);
    chk(16'(pattern_playing_out), 16'h0001);
    pd(1);
    chk(16'(pattern_playing_out), 16'h0000);
    wrap_up();
  end
endmodule
